/* rtl/dct_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.svh"
module dct_ctrl #(
    parameter int GRADE = `DCT_GRADE_FAST,
    parameter int DIV = `DCT_DIV,
    parameter int DW = 18,
    parameter int RAS_MAX_CYC = `DCT_RAS_MAX_NS / (`DCT_CLK_NS * `DCT_DIV)
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire dct_pkg::dct_cmd_t i_req_cmd,
    input wire logic [`DCT_BANK_W-1:0] i_req_bank,
    input wire logic [DW-1:0] i_req_wdata,
    input wire logic [3:0] i_read_delay,
    output logic o_req_ack,
    output logic o_rd_valid,
    output logic [DW-1:0] o_rd_data,
    output logic o_force_pre,
    dct_link_if.ctrl lnk
);
    import dct_pkg::*;
    localparam int NB = `DCT_BANKS;
    localparam int RQ = `DCT_CAC_MAX + 4;
    localparam int RC = (GRADE == `DCT_GRADE_FAST) ? `DCT_RC_FAST : `DCT_RC_SLOW;
    localparam int RASMIN = (GRADE == `DCT_GRADE_FAST) ? `DCT_RAS_FAST : `DCT_RAS_SLOW;
    localparam int RP = (GRADE == `DCT_GRADE_FAST) ? `DCT_RP_FAST : `DCT_RP_SLOW;
    localparam int RCD = (GRADE == `DCT_GRADE_40) ? `DCT_RCD_40 : `DCT_RCD;
    localparam int CACMIN = (GRADE == `DCT_GRADE_FAST) ? `DCT_CAC_MIN_FAST : `DCT_CAC_MIN_SLOW;

    typedef struct packed {
        logic [7:0] div;
        logic lclk;
        logic [NB-1:0][11:0] open_age;
        logic [NB-1:0][7:0] pre_age;
        logic [NB-1:0][7:0] rret_age;
        logic [NB-1:0] open;
        logic [NB-1:0] late;
        logic [7:0] any_open_age;
        logic [7:0] any_pre_age;
        logic [7:0] col_age;
        logic [7:0] wr_age;
        logic wr_pend;
        logic wr_auto;
        logic [`DCT_BANK_W-1:0] wr_bank;
        logic [1:0] row_ph;
        logic [1:0] col_ph;
        logic row_frame;
        logic [2:0] row_cmd;
        logic [`DCT_BANK_W-1:0] row_bank;
        logic col_frame;
        logic [2:0] col_cmd;
        logic [`DCT_BANK_W-1:0] col_bank;
        logic [`DCT_CWD-1:0] wq_v;
        logic [`DCT_CWD-1:0][DW-1:0] wq_d;
        logic [1:0] drv_cnt;
        logic dq_oe;
        logic [DW-1:0] dq_out;
        logic [RQ-1:0] rq_v;
        logic [DW-1:0] dq_s1;
        logic [DW-1:0] dq_s2;
        logic ack;
        logic rd_valid;
        logic [DW-1:0] rd_data;
        logic force_pre;
    } dct_ctrl_t;
    dct_ctrl_t r, next_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] sat8(input logic [7:0] v);
        sat8 = (v == 8'hFF) ? v : v + 8'h01;
    endfunction : sat8

    logic tick;
    logic [3:0] cac;
    logic force_hit;
    logic [`DCT_BANK_W-1:0] force_bank;
    logic [`DCT_BANK_W-1:0] b;
    logic ok_open;
    logic ok_pre;
    logic ok_col;
    logic go;
    dct_cmd_t cmd;

    assign tick = (r.div == 8'(DIV / 2 - 1));
    assign cac = (i_read_delay < 4'(CACMIN)) ? 4'(CACMIN) :
                 (i_read_delay > 4'(`DCT_CAC_MAX)) ? 4'(`DCT_CAC_MAX) : i_read_delay;

    // ------------------------------------------------------------
    // spacing checks
    // ------------------------------------------------------------
    // overdue open bank, lowest index wins
    always_comb begin
        force_hit = 1'b0;
        force_bank = '0;
        for (int i = NB - 1; i >= 0; i--) begin
            if (r.open[i] && r.open_age[i] >= 12'(RAS_MAX_CYC)) begin
                force_hit = 1'b1;
                force_bank = `DCT_BANK_W'(i);
            end
        end
    end

    always_comb begin
        cmd = force_hit ? CMD_ROW_PRECHARGE : i_req_cmd;
        b = force_hit ? force_bank : i_req_bank;
        ok_open = !r.open[b] && r.open_age[b] >= 12'(RC) && r.any_open_age >= 8'(`DCT_RR) &&
                  r.pre_age[b] >= (r.late[b] ? 8'(RP + `DCT_OFFP) : 8'(RP));
        ok_pre = r.open[b] && r.open_age[b] >= 12'(RASMIN) && r.any_pre_age >= 8'(`DCT_PP) &&
                 r.rret_age[b] >= 8'(`DCT_RDP);
        ok_col = r.col_ph == 2'h0 && r.col_age >= 8'(`DCT_CC) &&
                 (!r.wr_pend || r.wr_age >= 8'(`DCT_RTR)) &&
                 (!(r.wr_pend && r.wr_auto) || r.any_pre_age >= 8'(`DCT_PP));
        case (cmd)
            CMD_BANK_ACTIVATE: go = r.row_ph == 2'h0 && ok_open;
            CMD_ROW_PRECHARGE: go = r.row_ph == 2'h0 && ok_pre;
            CMD_READ, CMD_WRITE: go = ok_col && r.open[b] && r.open_age[b] >= 12'(RCD);
            CMD_READ_AUTOPRE, CMD_WRITE_AUTOPRE: go = ok_col && r.open[b] &&
                r.open_age[b] >= 12'(RCD) && r.any_pre_age >= 8'(`DCT_PP);
            // column precharges checked like row precharge
            default: go = ok_col && ok_pre;
        endcase
        go = go && tick && (force_hit || (i_req_valid && !r.ack));
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.ack = 1'b0;
        next_r.rd_valid = 1'b0;
        next_r.force_pre = 1'b0;
        next_r.dq_s1 = lnk.dq;
        next_r.dq_s2 = r.dq_s1;
        // link clock divider, rising edge starts a channel cycle
        next_r.div = (r.div == 8'(DIV - 1)) ? 8'h00 : r.div + 8'h01;
        next_r.lclk = next_r.div < 8'(DIV / 2);
        if (tick) begin
            for (int i = 0; i < NB; i++) begin
                next_r.open_age[i] = (r.open_age[i] == 12'hFFF) ? r.open_age[i] :
                                     r.open_age[i] + 12'h001;
                next_r.pre_age[i] = sat8(r.pre_age[i]);
                next_r.rret_age[i] = sat8(r.rret_age[i]);
            end
            next_r.any_open_age = sat8(r.any_open_age);
            next_r.any_pre_age = sat8(r.any_pre_age);
            next_r.col_age = sat8(r.col_age);
            next_r.wr_age = sat8(r.wr_age);
            next_r.row_frame = 1'b0;
            next_r.col_frame = 1'b0;
            if (r.row_ph != 2'h0) next_r.row_ph = r.row_ph - 2'h1;
            if (r.col_ph != 2'h0) next_r.col_ph = r.col_ph - 2'h1;
            // write data launched six cycles on
            next_r.wq_v = {1'b0, r.wq_v[`DCT_CWD-1:1]};
            next_r.wq_d = {{DW{1'b0}}, r.wq_d[`DCT_CWD-1:1]};
            if (r.drv_cnt != 2'h0) begin
                next_r.drv_cnt = r.drv_cnt - 2'h1;
            end else begin
                next_r.dq_oe = 1'b0;
            end
            if (r.wq_v[0]) begin
                next_r.dq_out = r.wq_d[0];
                next_r.dq_oe = 1'b1;
                next_r.drv_cnt = 2'(`DCT_PACKET - 1);
            end
            // read sample taken early in data window, about 6 clocks after the device starts driving
            next_r.rq_v = {1'b0, r.rq_v[RQ-1:1]};
            if (r.rq_v[0]) begin
                next_r.rd_valid = 1'b1;
                next_r.rd_data = r.dq_s2;
            end
        end
        if (go) begin
            next_r.ack = !force_hit;
            next_r.force_pre = force_hit;
            if (cmd == CMD_BANK_ACTIVATE || cmd == CMD_ROW_PRECHARGE) begin
                next_r.row_frame = 1'b1;
                next_r.row_cmd = cmd;
                next_r.row_bank = b;
                next_r.row_ph = 2'(`DCT_PACKET - 1);
            end else begin
                next_r.col_frame = 1'b1;
                next_r.col_cmd = cmd;
                next_r.col_bank = b;
                next_r.col_ph = 2'(`DCT_PACKET - 1);
                next_r.col_age = '0;
                // column packet retires any pending write
                if (r.wr_pend) begin
                    next_r.wr_pend = 1'b0;
                    next_r.rret_age[r.wr_bank] = '0;
                    if (r.wr_auto) begin
                        next_r.open[r.wr_bank] = 1'b0;
                        next_r.late[r.wr_bank] = 1'b1;
                        next_r.pre_age[r.wr_bank] = '0;
                        next_r.any_pre_age = '0;
                    end
                end
            end
            case (cmd)
                CMD_BANK_ACTIVATE: begin
                    next_r.open[b] = 1'b1;
                    next_r.open_age[b] = '0;
                    next_r.any_open_age = '0;
                end
                CMD_ROW_PRECHARGE: begin
                    next_r.open[b] = 1'b0;
                    next_r.late[b] = 1'b0;
                    next_r.pre_age[b] = '0;
                    next_r.any_pre_age = '0;
                end
                CMD_WRITE, CMD_WRITE_AUTOPRE: begin
                    next_r.wr_pend = 1'b1;
                    next_r.wr_auto = cmd == CMD_WRITE_AUTOPRE;
                    next_r.wr_bank = b;
                    next_r.wr_age = '0;
                    next_r.wq_v[`DCT_CWD-1] = 1'b1;
                    next_r.wq_d[`DCT_CWD-1] = i_req_wdata;
                end
                CMD_READ, CMD_READ_AUTOPRE: begin
                    next_r.rret_age[b] = '0;
                    next_r.rq_v[cac + 4'h1] = 1'b1;
                end
                default: begin
                end
            endcase
            if (cmd == CMD_READ_AUTOPRE || cmd == CMD_COLUMN_PRECHARGE ||
                cmd == CMD_EXTENDED_PRECHARGE) begin
                next_r.open[b] = 1'b0;
                next_r.late[b] = 1'b1;
                next_r.pre_age[b] = '0;
                next_r.any_pre_age = '0;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
            // counters start saturated so the first packets pass
            r.open_age <= '1;
            r.pre_age <= '1;
            r.rret_age <= '1;
            r.any_open_age <= '1;
            r.any_pre_age <= '1;
            r.col_age <= '1;
            r.wr_age <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign o_req_ack = r.ack;
    assign o_rd_valid = r.rd_valid;
    assign o_rd_data = r.rd_data;
    assign o_force_pre = r.force_pre;
    assign lnk.lclk = r.lclk;
    assign lnk.row_frame = r.row_frame;
    assign lnk.row_cmd = r.row_cmd;
    assign lnk.row_bank = r.row_bank;
    assign lnk.col_frame = r.col_frame;
    assign lnk.col_cmd = r.col_cmd;
    assign lnk.col_bank = r.col_bank;
    assign lnk.dq_c = r.dq_out;
    assign lnk.dq_c_oe = r.dq_oe;
endmodule : dct_ctrl
`default_nettype wire

/* rtl/dct_defs.svh */
// Summary of operation
// - same-bank activates 32 (28 slow) apart
// - activate to precharge 22/20, max 64us; read/write autoprecharge only waits activate to column 9
// - precharge to same-bank activate 10/8
// - device precharges at least 8 apart; code spaces packets 8, an implied one may act 4 from a row precharge
// - device activates at least 8 apart
// - activate to column 9, grade -40 7
// - core sees column one cycle later
// - read data after programmable 9/8..12
// - write data exactly 6 cycles later
// - column packets at least 4 apart
// - every packet lasts 4 cycles
// - retire and mask 8 after write
// - implied precharge acts 4 cycles later
// - read to precharge at least 4
// - retire to precharge at least 4
// - column precharges obey row precharge spacing
`ifndef DCT_DEFS_SVH
`define DCT_DEFS_SVH
`define DCT_CLK_NS 10
`define DCT_DIV 8
`define DCT_BANKS 32
`define DCT_BANK_W 5
`define DCT_GRADE_FAST 0
`define DCT_GRADE_40 2
`define DCT_RC_FAST 32
`define DCT_RC_SLOW 28
`define DCT_RAS_FAST 22
`define DCT_RAS_SLOW 20
`define DCT_RAS_MAX_NS 64000
`define DCT_RP_FAST 10
`define DCT_RP_SLOW 8
`define DCT_PP 8
`define DCT_RR 8
`define DCT_RCD 9
`define DCT_RCD_40 7
`define DCT_CORE_COL_DLY 1
`define DCT_CAC_MIN_FAST 9
`define DCT_CAC_MIN_SLOW 8
`define DCT_CAC_MAX 12
`define DCT_CWD 6
`define DCT_CC 4
`define DCT_PACKET 4
`define DCT_RTR 8
`define DCT_OFFP 4
`define DCT_RDP 4
`define DCT_RTP 4
`endif

/* rtl/dct_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dct_defs.svh"
module dct_dev #(
    parameter int GRADE = `DCT_GRADE_FAST,
    parameter int DW = 18
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [3:0] i_read_delay,
    input wire logic [DW-1:0] i_rd_data,
    output logic o_core_open,
    output logic o_core_pre,
    output logic o_core_col,
    output dct_pkg::dct_cmd_t o_core_col_cmd,
    output logic [`DCT_BANK_W-1:0] o_core_bank,
    output logic [`DCT_BANK_W-1:0] o_core_pre_bank,
    output logic o_wr_valid,
    output logic [`DCT_BANK_W-1:0] o_wr_bank,
    output logic [DW-1:0] o_wr_data,
    dct_link_if.dev lnk
);
    import dct_pkg::*;
    localparam int BW = `DCT_BANK_W;
    localparam int SW = 1 + 2 * (1 + 3 + BW) + DW;
    localparam int CACMIN = (GRADE == `DCT_GRADE_FAST) ? `DCT_CAC_MIN_FAST : `DCT_CAC_MIN_SLOW;

    typedef struct packed {
        logic lprev;
        logic [`DCT_CORE_COL_DLY-1:0] cd_v;
        logic [2:0] cd_cmd;
        logic [BW-1:0] cd_bank;
        logic [`DCT_CAC_MAX-1:0] rq_v;
        logic [`DCT_CAC_MAX-1:0][DW-1:0] rq_d;
        logic [1:0] drv_cnt;
        logic dq_oe;
        logic [DW-1:0] dq_out;
        logic [`DCT_CWD-1:0] ws_v;
        logic [`DCT_CWD-1:0][BW-1:0] ws_bank;
        logic [`DCT_OFFP-1:0] pl_v;
        logic [`DCT_OFFP-1:0][BW-1:0] pl_bank;
        logic wr_pend;
        logic wr_auto;
        logic [BW-1:0] wr_bank;
        logic core_open;
        logic core_pre;
        logic core_col;
        logic [2:0] core_col_cmd;
        logic [BW-1:0] core_bank;
        logic [BW-1:0] core_pre_bank;
        logic wr_valid;
        logic [BW-1:0] wr_bank_o;
        logic [DW-1:0] wr_data;
    } dct_dev_t;
    dct_dev_t r, next_r;

    logic [SW-1:0] s;
    logic s_lclk;
    logic s_rf;
    logic [2:0] s_rc;
    logic [BW-1:0] s_rb;
    logic s_cf;
    logic [2:0] s_cc;
    logic [BW-1:0] s_cb;
    logic [DW-1:0] s_dq;
    logic tick;
    logic [3:0] cac;

    // ------------------------------------------------------------
    // link inputs cross into the block clock
    // ------------------------------------------------------------
    dct_sync #(.W(SW)) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({lnk.lclk, lnk.row_frame, lnk.row_cmd, lnk.row_bank,
                  lnk.col_frame, lnk.col_cmd, lnk.col_bank, lnk.dq}),
        .o_sync(s)
    );
    assign {s_lclk, s_rf, s_rc, s_rb, s_cf, s_cc, s_cb, s_dq} = s;
    // rising link clock marks one channel cycle
    assign tick = s_lclk && !r.lprev;
    // programmed latency clamped to legal range
    assign cac = (i_read_delay < 4'(CACMIN)) ? 4'(CACMIN) :
                 (i_read_delay > 4'(`DCT_CAC_MAX)) ? 4'(`DCT_CAC_MAX) : i_read_delay;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.lprev = s_lclk;
        next_r.core_open = 1'b0;
        next_r.core_pre = 1'b0;
        next_r.core_col = 1'b0;
        next_r.wr_valid = 1'b0;
        if (tick) begin
            // delay lines advance one channel cycle
            next_r.rq_v = {1'b0, r.rq_v[`DCT_CAC_MAX-1:1]};
            next_r.rq_d = {{DW{1'b0}}, r.rq_d[`DCT_CAC_MAX-1:1]};
            next_r.ws_v = {1'b0, r.ws_v[`DCT_CWD-1:1]};
            next_r.ws_bank = {{BW{1'b0}}, r.ws_bank[`DCT_CWD-1:1]};
            next_r.pl_v = {1'b0, r.pl_v[`DCT_OFFP-1:1]};
            next_r.pl_bank = {{BW{1'b0}}, r.pl_bank[`DCT_OFFP-1:1]};
            if (r.drv_cnt != 2'h0) begin
                next_r.drv_cnt = r.drv_cnt - 2'h1;
            end else begin
                next_r.dq_oe = 1'b0;
            end
            if (r.rq_v[0]) begin
                next_r.dq_out = r.rq_d[0];
                next_r.dq_oe = 1'b1;
                next_r.drv_cnt = 2'(`DCT_PACKET - 1);
            end
            if (r.ws_v[0]) begin
                next_r.wr_valid = 1'b1;
                next_r.wr_bank_o = r.ws_bank[0];
                next_r.wr_data = s_dq;
            end
            // row path reaches the core at once
            if (s_rf) begin
                next_r.core_bank = s_rb;
                next_r.core_open = s_rc == 3'(CMD_BANK_ACTIVATE);
                next_r.core_pre = s_rc == 3'(CMD_ROW_PRECHARGE);
                next_r.core_pre_bank = s_rb;
            end
            if (r.pl_v[0]) begin
                next_r.core_pre = 1'b1;
                next_r.core_pre_bank = r.pl_bank[0];
            end
            next_r.cd_v = s_cf;
            next_r.cd_cmd = s_cc;
            next_r.cd_bank = s_cb;
            if (r.cd_v[0]) begin
                next_r.core_col = 1'b1;
                next_r.core_col_cmd = r.cd_cmd;
                next_r.core_bank = r.cd_bank;
            end
            if (s_cf) begin
                // next column packet retires the pending write
                if (r.wr_pend) begin
                    next_r.wr_pend = 1'b0;
                    if (r.wr_auto) begin
                        next_r.pl_v[`DCT_OFFP-1] = 1'b1;
                        next_r.pl_bank[`DCT_OFFP-1] = r.wr_bank;
                    end
                end
                case (s_cc)
                    3'(CMD_READ), 3'(CMD_READ_AUTOPRE): begin
                        next_r.rq_v[cac - 4'h1] = 1'b1;
                        next_r.rq_d[cac - 4'h1] = i_rd_data;
                    end
                    3'(CMD_WRITE), 3'(CMD_WRITE_AUTOPRE): begin
                        next_r.wr_pend = 1'b1;
                        next_r.wr_auto = s_cc == 3'(CMD_WRITE_AUTOPRE);
                        next_r.wr_bank = s_cb;
                        next_r.ws_v[`DCT_CWD-1] = 1'b1;
                        next_r.ws_bank[`DCT_CWD-1] = s_cb;
                    end
                    default: begin
                    end
                endcase
                if (s_cc == 3'(CMD_READ_AUTOPRE) || s_cc == 3'(CMD_COLUMN_PRECHARGE) ||
                    s_cc == 3'(CMD_EXTENDED_PRECHARGE)) begin
                    next_r.pl_v[`DCT_OFFP-1] = 1'b1;
                    next_r.pl_bank[`DCT_OFFP-1] = s_cb;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_core_open = r.core_open;
    assign o_core_pre = r.core_pre;
    assign o_core_col = r.core_col;
    assign o_core_col_cmd = dct_cmd_t'(r.core_col_cmd);
    assign o_core_bank = r.core_bank;
    assign o_core_pre_bank = r.core_pre_bank;
    assign o_wr_valid = r.wr_valid;
    assign o_wr_bank = r.wr_bank_o;
    assign o_wr_data = r.wr_data;
    assign lnk.dq_d = r.dq_out;
    assign lnk.dq_d_oe = r.dq_oe;
endmodule : dct_dev
`default_nettype wire

/* rtl/dct_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dct_link_if #(parameter int DW = 18);
    logic lclk;
    logic row_frame;
    logic [2:0] row_cmd;
    logic [4:0] row_bank;
    logic col_frame;
    logic [2:0] col_cmd;
    logic [4:0] col_bank;
    logic [DW-1:0] dq_c;
    logic dq_c_oe;
    logic [DW-1:0] dq_d;
    logic dq_d_oe;
    logic [DW-1:0] dq;
    // resolved data bus level from the two enables
    assign dq = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : '0);
    modport ctrl (output lclk, row_frame, row_cmd, row_bank, col_frame, col_cmd, col_bank,
                  dq_c, dq_c_oe, input dq);
    modport dev (input lclk, row_frame, row_cmd, row_bank, col_frame, col_cmd, col_bank, dq,
                 output dq_d, dq_d_oe);
endinterface : dct_link_if
`default_nettype wire

/* rtl/dct_pkg.sv */
package dct_pkg;
    // command codes carried in row and column packets
    typedef enum logic [2:0] {
        CMD_BANK_ACTIVATE = 3'h0,
        CMD_ROW_PRECHARGE = 3'h1,
        CMD_READ = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_READ_AUTOPRE = 3'h4,
        CMD_WRITE_AUTOPRE = 3'h5,
        CMD_COLUMN_PRECHARGE = 3'h6,
        CMD_EXTENDED_PRECHARGE = 3'h7
    } dct_cmd_t;
endpackage : dct_pkg

/* rtl/dct_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dct_sync #(parameter int W = 8) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dct_sync_t;
    dct_sync_t r, next_r;
    // first stage feeds only the second
    always_comb begin
        next_r = r;
        next_r.s1 = i_async;
        next_r.s2 = r.s1;
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign o_sync = r.s2;
endmodule : dct_sync
`default_nettype wire

/* verif/dct_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dct_link_props
    import dct_pkg::*;
#(
    parameter int RD_LAT = 10
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic row_frame,
    input wire logic [2:0] row_cmd,
    input wire logic col_frame,
    input wire logic [2:0] col_cmd,
    input wire logic dq_c_oe,
    input wire logic dq_d_oe
);
    // read window allows for the device's lclk sync delay
    localparam int RLO = 8 * RD_LAT + 3;
    localparam int RHI = 8 * RD_LAT + 11;
    logic rf_q;
    logic cf_q;
    logic wr_q;
    logic [7:0] gap [3];
    logic [2:0] hit;
    // packet starts: column, row precharge, activate
    assign hit = {col_frame & ~cf_q, row_frame & ~rf_q & (row_cmd == CMD_ROW_PRECHARGE),
                  row_frame & ~rf_q & (row_cmd == CMD_BANK_ACTIVATE)};
    // gaps in i_clk cycles, saturating so long idle never wraps
    always_ff @(posedge i_clk) begin
        rf_q <= row_frame;
        cf_q <= col_frame;
        if (i_reset) wr_q <= 1'b0;
        else if (hit[2]) wr_q <= (col_cmd == CMD_WRITE) || (col_cmd == CMD_WRITE_AUTOPRE);
        for (int k = 0; k < 3; k++) begin
            if (i_reset) gap[k] <= 8'hFF;
            else if (hit[k]) gap[k] <= 8'h01;
            else if (gap[k] != 8'hFF) gap[k] <= gap[k] + 8'h01;
        end
    end
    // ------------------------------
    // link timing
    // ------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_act_spacing: assert property (hit[0] |-> gap[0] >= 8'h40)
        else $error("activates too close");
    a_pre_spacing: assert property (hit[1] |-> gap[1] >= 8'h40)
        else $error("precharges too close");
    a_col_spacing: assert property (hit[2] |-> gap[2] >= (wr_q ? 8'h40 : 8'h20))
        else $error("column packets too close");
    a_row_frame_len: assert property ($rose(row_frame) |-> row_frame[*8] ##1 !row_frame)
        else $error("row frame length wrong");
    a_col_frame_len: assert property ($rose(col_frame) |-> col_frame[*8] ##1 !col_frame)
        else $error("column frame length wrong");
    a_row_pkt_hold: assert property (row_frame |-> ##24 (row_cmd == $past(row_cmd, 24)))
        else $error("row packet not held");
    a_write_lat: assert property (hit[2] &&
        (col_cmd == CMD_WRITE || col_cmd == CMD_WRITE_AUTOPRE) |-> ##[44:52] $rose(dq_c_oe))
        else $error("write data offset wrong");
    a_read_lat: assert property (hit[2] &&
        (col_cmd == CMD_READ || col_cmd == CMD_READ_AUTOPRE) |-> ##[RLO:RHI] $rose(dq_d_oe))
        else $error("read data offset wrong");
    a_read_burst: assert property ($rose(dq_d_oe) |-> ##28 dq_d_oe ##[1:8] !dq_d_oe)
        else $error("read burst length wrong");
    a_bus_excl: assert property (!(dq_c_oe && dq_d_oe))
        else $error("data bus driven by both ends");
    c_act: cover property (hit[0]);
    c_write: cover property ($rose(dq_c_oe));
    c_read: cover property ($rose(dq_d_oe));
endmodule : dct_link_props
`default_nettype wire

/* verif/test_dram_channel_command_timing.sv */
`timescale 1ns/1ps
`default_nettype none
module test_dram_channel_command_timing;
    import dct_pkg::*;
    localparam int RD = 10;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic req_v = 1'b0;
    dct_cmd_t req_c = CMD_BANK_ACTIVATE;
    logic [4:0] req_b = 5'h00;
    logic [17:0] req_d = 18'h00000;
    logic [17:0] rdat = 18'h1C3C3;
    logic ack, rd_v, fpre, c_open, c_pre, wr_v, c_col;
    logic [5:0] ev;
    logic [17:0] rd_d, wr_d, wd, rq;
    logic [4:0] c_bank, p_bank, wr_b, pb, wb;
    int bad_count = 0;
    int checked = 0;
    int n [6];
    dct_link_if #(.DW(18)) lnk();
    dct_ctrl #(.RAS_MAX_CYC(100)) i_dct_ctrl(.i_clk(i_clk), .i_reset(i_reset),
        .i_req_valid(req_v), .i_req_cmd(req_c), .i_req_bank(req_b), .i_req_wdata(req_d),
        .i_read_delay(4'hA), .o_req_ack(ack), .o_rd_valid(rd_v), .o_rd_data(rd_d),
        .o_force_pre(fpre), .lnk(lnk.ctrl));
    dct_dev i_dct_dev(.i_clk(i_clk), .i_reset(i_reset), .i_read_delay(4'hA), .i_rd_data(rdat),
        .o_core_open(c_open), .o_core_pre(c_pre), .o_core_col(c_col), .o_core_col_cmd(),
        .o_core_bank(c_bank), .o_core_pre_bank(p_bank), .o_wr_valid(wr_v), .o_wr_bank(wr_b),
        .o_wr_data(wr_d), .lnk(lnk.dev));
    dct_link_props #(.RD_LAT(RD)) i_dct_link_props(.i_clk(i_clk), .i_reset(i_reset),
        .row_frame(lnk.row_frame), .row_cmd(lnk.row_cmd), .col_frame(lnk.col_frame),
        .col_cmd(lnk.col_cmd), .dq_c_oe(lnk.dq_c_oe), .dq_d_oe(lnk.dq_d_oe));
    always #5 i_clk = ~i_clk;
    // ------------------------------
    // event capture: pulses are one clock wide
    // ------------------------------
    assign ev = {c_col, fpre, rd_v, wr_v, c_pre, c_open};
    always @(posedge i_clk) begin
        for (int k = 0; k < 6; k++) begin
            if (ev[k] === 1'b1) n[k] <= n[k] + 1;
        end
        if (c_pre === 1'b1) pb <= p_bank;
        if (rd_v === 1'b1) rq <= rd_d;
        if (wr_v === 1'b1) wd <= wr_d;
        if (wr_v === 1'b1) wb <= wr_b;
    end
    task automatic finish_test();
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    // request held until ack; a stalled controller ends the run
    task automatic req(input dct_cmd_t c, input logic [4:0] b, input logic [17:0] d);
        int t;
        t = 0;
        @(posedge i_clk);
        req_v <= 1'b1;
        req_c <= c;
        req_b <= b;
        req_d <= d;
        do begin
            @(posedge i_clk);
            t++;
        end while (ack !== 1'b1 && t < 4000);
        req_v <= 1'b0;
        chk(t < 4000, "no ack");
        if (t >= 4000) finish_test();
    endtask : req
    task automatic wait_n(input int k, input int v);
        int t;
        t = 0;
        while (n[k] < v && t < 4000) begin
            @(posedge i_clk);
            t++;
        end
        chk(t < 4000, "event timeout");
        if (t >= 4000) finish_test();
    endtask : wait_n
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        req(CMD_BANK_ACTIVATE, 5'h03, 18'h00000);
        req(CMD_BANK_ACTIVATE, 5'h07, 18'h00000);
        wait_n(0, 2);
        req(CMD_WRITE, 5'h03, 18'h2A5A5);
        wait_n(2, 1);
        chk(wd === 18'h2A5A5 && wb === 5'h03, "write data");
        req(CMD_READ, 5'h07, 18'h00000);
        wait_n(3, 1);
        chk(rq === 18'h1C3C3, "read data");
        req(CMD_WRITE_AUTOPRE, 5'h03, 18'h15A5A);
        req(CMD_READ, 5'h07, 18'h00000);
        wait_n(1, 1);
        chk(pb === 5'h03 && wd === 18'h15A5A, "retire precharge");
        req(CMD_READ_AUTOPRE, 5'h07, 18'h00000);
        wait_n(1, 2);
        chk(pb === 5'h07 && n[3] >= 2, "read autoprecharge");
        req(CMD_BANK_ACTIVATE, 5'h03, 18'h00000);
        req(CMD_ROW_PRECHARGE, 5'h03, 18'h00000);
        req(CMD_BANK_ACTIVATE, 5'h07, 18'h00000);
        req(CMD_COLUMN_PRECHARGE, 5'h07, 18'h00000);
        wait_n(1, 4);
        chk(pb === 5'h07, "column precharge");
        req(CMD_BANK_ACTIVATE, 5'h03, 18'h00000);
        req(CMD_EXTENDED_PRECHARGE, 5'h03, 18'h00000);
        wait_n(1, 5);
        chk(pb === 5'h03, "extended precharge");
        req(CMD_BANK_ACTIVATE, 5'h1F, 18'h00000);
        wait_n(4, 1);
        wait_n(1, 6);
        chk(pb === 5'h1F && n[0] == 6 && n[5] == 7 && c_bank === 5'h1F,
            "overdue bank closed");
        finish_test();
    end
endmodule : test_dram_channel_command_timing
`default_nettype wire
